// file: verilog/sar_pkg.sv
// Package for the stereo serial audio link: framing constants, formats, timing counts.
// Assumes both link ends and the bench import it; no clocks or resets live here.
package sar_pkg;

  // Framing formats selectable on both ends
  typedef enum logic {
    SAR_FMT_I2S,
    SAR_FMT_LEFT_JUSTIFIED
  } sar_fmt_e;

  // Slot layout: two slots per frame
  localparam int SAR_SLOT_BITS = 32;
  localparam int SAR_FRAME_BITS = 64;
  localparam logic [6:0] SAR_FRAME_EDGES = 7'h40;
  localparam logic [5:0] SAR_LAST_POS = 6'h3f;

  // Default audio word width
  localparam int SAR_WORD_W = 24;

  // Allowed frame clock drift, in master clock periods, before resync
  localparam logic [15:0] SAR_DRIFT_MCLKS = 16'h000a;

  // Source side bit clock divider: master clock cycles per half bit clock
  localparam logic [7:0] SAR_BCLK_HALF_CYCLES = 8'h02;

  // Reset values of the link pins driven by the source
  localparam logic SAR_BCLK_RST = 1'b0;
  localparam logic SAR_LRCLK_RST = 1'b0;
  localparam logic SAR_DATA_RST = 1'b0;

endpackage

// file: verilog/sar_if.sv
// Interface joining the audio source and the audio receiver: bit clock, frame clock, data.
// Assumes the source end drives all three wires; the receiver only listens.
`timescale 1ns/10ps
interface sar_if;
  logic bit_clk;
  logic frame_clk;
  logic serial_data_in;

  // Source end drives the link
  modport src (
    output bit_clk,
    output frame_clk,
    output serial_data_in
  );

  // Receiving end samples the link
  modport rcv (
    input bit_clk,
    input frame_clk,
    input serial_data_in
  );
endinterface

// file: verilog/sar_tx.sv
// Audio source end: derives the bit clock from clk_in, drives frame clock and serial data.
// Assumes the user presents a left/right pair at any time; it is taken at the next frame start.
`timescale 1ns/10ps
module sar_tx #(
  parameter int WORD_W = sar_pkg::SAR_WORD_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Configuration
  input wire sar_pkg::sar_fmt_e fmt_in,
  // User samples
  input wire logic sample_valid_in,
  input wire logic [WORD_W-1:0] left_in,
  input wire logic [WORD_W-1:0] right_in,
  output logic frame_start_out,
  // Link
  sar_if.src link
);
  import sar_pkg::*;

  logic [7:0] div_cnt;
  logic bclk;
  logic lrclk;
  logic sdata;
  logic [5:0] pos;
  logic [WORD_W-1:0] hold_left;
  logic [WORD_W-1:0] hold_right;
  logic [WORD_W-1:0] cur_left;
  logic [WORD_W-1:0] cur_right;
  logic fall;
  logic [5:0] next_pos;
  logic [5:0] slot_pos;
  logic next_lr;
  logic next_bit;
  logic [WORD_W-1:0] word;
  int idx;

  assign link.bit_clk = bclk;
  assign link.frame_clk = lrclk;
  assign link.serial_data_in = sdata;

  // Bit clock falls when the divider expires while it is high
  assign fall = (div_cnt == SAR_BCLK_HALF_CYCLES - 8'h01) && bclk;
  assign next_pos = pos + 6'h01;

  // Level and data bit for the next bit position
  always_comb begin
    slot_pos = {1'b0, next_pos[4:0]};
    word = next_pos[5] ? cur_right : cur_left;
    if (next_pos == 6'h00) begin
      word = hold_left;
    end
    next_bit = 1'b0;
    if (fmt_in == SAR_FMT_LEFT_JUSTIFIED) begin
      next_lr = ~next_pos[5];
      idx = int'(slot_pos);
    end else begin
      next_lr = next_pos[5];
      idx = int'(slot_pos) - 1;
    end
    // MSB first, trailing positions zero
    if (idx >= 0 && idx < WORD_W) begin
      next_bit = word[WORD_W-1-idx];
    end
  end

  // Bit clock divider: toggles every SAR_BCLK_HALF_CYCLES master clock cycles
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_cnt <= 8'h00;
      bclk <= SAR_BCLK_RST;
    end else if (div_cnt == SAR_BCLK_HALF_CYCLES - 8'h01) begin
      div_cnt <= 8'h00;
      bclk <= ~bclk;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // Frame clock and data change on the falling bit clock edge
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pos <= SAR_LAST_POS;
      lrclk <= SAR_LRCLK_RST;
      sdata <= SAR_DATA_RST;
    end else if (fall) begin
      pos <= next_pos;
      lrclk <= next_lr;
      sdata <= next_bit;
    end
  end

  // Sample holding and per-frame copy
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hold_left <= '0;
      hold_right <= '0;
      cur_left <= '0;
      cur_right <= '0;
      frame_start_out <= 1'b0;
    end else begin
      frame_start_out <= 1'b0;
      if (sample_valid_in) begin
        hold_left <= left_in;
        hold_right <= right_in;
      end
      if (fall && next_pos == 6'h00) begin
        cur_left <= hold_left;
        cur_right <= hold_right;
        frame_start_out <= 1'b1;
      end
    end
  end

endmodule

// file: verilog/sar_rx.sv
// Audio receiver end: captures serial words on the link bit clock, hands pairs to clk_in.
// Assumes a free-standing source drives the link; bit clock runs on, as a stop over SAR_DRIFT_MCLKS master clocks forces a resync.
// The framing check on the master clock side resyncs the bit side by a toggle crossing.
`timescale 1ns/10ps

module sar_rx #(
  parameter int WORD_W = sar_pkg::SAR_WORD_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Configuration
  input wire sar_pkg::sar_fmt_e fmt_in,
  // Received samples
  output logic [WORD_W-1:0] left_out,
  output logic [WORD_W-1:0] right_out,
  output logic sample_valid_out,
  // Framing status
  output logic resync_out,
  output logic frame_err_out,
  // Link
  sar_if.rcv link
);
  import sar_pkg::*;

  // ---- master clock domain state
  sar_fmt_e fmt_q;
  logic rs_tgl;
  logic done_m;
  logic done_s;
  logic done_d;
  logic err_m;
  logic err_s;
  logic err_d;
  logic lr_m;
  logic lr_s;
  logic lr_d;
  logic [15:0] per_cnt;
  logic [15:0] last_per;
  logic have_last;
  logic have_per;
  logic [15:0] drift;

  // ---- bit clock domain state
  logic fmt_m;
  logic fmt_s;
  logic rs_m;
  logic rs_s;
  logic rs_d;
  logic lr_prev;
  logic active;
  logic [5:0] bit_idx;
  logic [WORD_W-1:0] shreg;
  logic chan_left;
  logic [WORD_W-1:0] word_hold;
  logic word_left;
  logic done_tgl;
  logic [6:0] edge_cnt;
  logic err_tgl;
  logic lr_now;
  logic sd_now;
  logic lj_mode;
  logic resync_hit;

  assign lr_now = link.frame_clk;
  assign sd_now = link.serial_data_in;
  assign lj_mode = fmt_s;
  assign resync_hit = rs_s != rs_d;

  // Format register on the master clock side
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fmt_q <= SAR_FMT_I2S;
    end else begin
      fmt_q <= fmt_in;
    end
  end

  // Format level and resync toggle cross into the bit clock domain
  always_ff @(posedge link.bit_clk or negedge nrst_in) begin
    if (!nrst_in) begin
      fmt_m <= 1'b0;
      fmt_s <= 1'b0;
      rs_m <= 1'b0;
      rs_s <= 1'b0;
      rs_d <= 1'b0;
    end else begin
      fmt_m <= (fmt_q == SAR_FMT_LEFT_JUSTIFIED);
      fmt_s <= fmt_m;
      rs_m <= rs_tgl;
      rs_s <= rs_m;
      rs_d <= rs_s;
    end
  end

  // Word capture on the rising bit clock edge
  always_ff @(posedge link.bit_clk or negedge nrst_in) begin
    if (!nrst_in) begin
      lr_prev <= 1'b0;
      active <= 1'b0;
      bit_idx <= 6'h00;
      shreg <= '0;
      chan_left <= 1'b0;
      word_hold <= '0;
      word_left <= 1'b0;
      done_tgl <= 1'b0;
    end else begin
      lr_prev <= lr_now;
      if (resync_hit) begin
        // Drop the word in flight and wait for the next frame edge
        active <= 1'b0;
        bit_idx <= 6'h00;
      end else if (lr_now != lr_prev) begin
        // Channel by frame clock level, polarity per format
        chan_left <= lj_mode ? lr_now : ~lr_now;
        if (lj_mode) begin
          shreg <= {shreg[WORD_W-2:0], sd_now};
          bit_idx <= 6'h01;
        end else begin
          bit_idx <= 6'h00;
        end
        active <= 1'b1;
      end else if (active) begin
        // MSB first; once the word is full the rest of the slot is not taken
        shreg <= {shreg[WORD_W-2:0], sd_now};
        bit_idx <= bit_idx + 6'h01;
        if (bit_idx == 6'(WORD_W - 1)) begin
          word_hold <= {shreg[WORD_W-2:0], sd_now};
          word_left <= chan_left;
          done_tgl <= ~done_tgl;
          active <= 1'b0;
        end
      end
    end
  end

  // Count bit edges per frame; a short or long frame raises an error event
  always_ff @(posedge link.bit_clk or negedge nrst_in) begin
    if (!nrst_in) begin
      edge_cnt <= 7'h00;
      err_tgl <= 1'b0;
    end else if (lr_now && !lr_prev) begin
      edge_cnt <= 7'h01;
      if (edge_cnt != SAR_FRAME_EDGES && edge_cnt != 7'h00) begin
        err_tgl <= ~err_tgl;
      end
    end else if (edge_cnt != 7'h00 && edge_cnt != 7'h7f) begin
      // Idle at zero until the first frame rise, so reset never looks like a short frame
      edge_cnt <= edge_cnt + 7'h01;
    end
  end

  // Word-done and error toggles cross back to the master clock
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      done_m <= 1'b0;
      done_s <= 1'b0;
      done_d <= 1'b0;
      err_m <= 1'b0;
      err_s <= 1'b0;
      err_d <= 1'b0;
    end else begin
      done_m <= done_tgl;
      done_s <= done_m;
      done_d <= done_s;
      err_m <= err_tgl;
      err_s <= err_m;
      err_d <= err_s;
    end
  end

  // Word hold stays stable for a whole slot, so it is read after the toggle settles
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      left_out <= '0;
      right_out <= '0;
      sample_valid_out <= 1'b0;
      frame_err_out <= 1'b0;
    end else begin
      sample_valid_out <= 1'b0;
      frame_err_out <= err_s != err_d;
      if (done_s != done_d) begin
        if (word_left) begin
          left_out <= word_hold;
        end else begin
          right_out <= word_hold;
          sample_valid_out <= 1'b1;
        end
      end
    end
  end

  // Synchronise the frame clock into the master clock domain
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lr_m <= 1'b0;
      lr_s <= 1'b0;
      lr_d <= 1'b0;
    end else begin
      lr_m <= lr_now;
      lr_s <= lr_m;
      lr_d <= lr_s;
    end
  end

  // Distance between this frame period and the last one
  always_comb begin
    if (per_cnt > last_per) begin
      drift = per_cnt - last_per;
    end else begin
      drift = last_per - per_cnt;
    end
  end

  // Frame period watch: drift beyond the limit resyncs the bit side
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      per_cnt <= 16'h0000;
      last_per <= 16'h0000;
      have_last <= 1'b0;
      have_per <= 1'b0;
      rs_tgl <= 1'b0;
      resync_out <= 1'b0;
    end else begin
      resync_out <= 1'b0;
      if (lr_s && !lr_d) begin
        per_cnt <= 16'h0001;
        last_per <= per_cnt;
        // The count up to the first rise began at reset, not at a frame edge
        have_per <= 1'b1;
        have_last <= have_per;
        if (have_last && drift > SAR_DRIFT_MCLKS) begin
          rs_tgl <= ~rs_tgl;
          resync_out <= 1'b1;
        end
      end else if (per_cnt != 16'hffff) begin
        per_cnt <= per_cnt + 16'h0001;
      end
    end
  end

endmodule

// file: tb/sar_sva.sv
// Checker of the audio link wires on the source clock.
// Assumes every link wire is a register of the source on clk_in.
`timescale 1ns/10ps
module sar_sva import sar_pkg::*; (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Link
  input wire logic bit_clk,
  input wire logic frame_clk,
  input wire logic serial_data_in
);
  logic seen_chg;
  logic seen_rise;
  logic [6:0] half_cnt;
  logic [6:0] frm_cnt;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  // Bit rises since the last frame clock change
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      half_cnt <= 7'h00;
    end else begin
      half_cnt <= $changed(frame_clk) ? 7'h00 : half_cnt + 7'($rose(bit_clk));
    end
  end
  // Bit rises since the last frame clock rise
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      frm_cnt <= 7'h00;
    end else begin
      frm_cnt <= $rose(frame_clk) ? 7'h00 : frm_cnt + 7'($rose(bit_clk));
    end
  end
  // Skip the partial frame after reset
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      seen_chg <= 1'b0;
      seen_rise <= 1'b0;
    end else begin
      seen_chg <= seen_chg | $changed(frame_clk);
      seen_rise <= seen_rise | $rose(frame_clk);
    end
  end
  a_bclk_high: assert property ($rose(bit_clk) |=> $stable(bit_clk) ##1 $fell(bit_clk))
    else $error("bit clock high phase wrong");
  a_bclk_low: assert property ($fell(bit_clk) |=> $stable(bit_clk) ##1 $rose(bit_clk))
    else $error("bit clock low phase wrong");
  a_frame_edge: assert property ($changed(frame_clk) |-> $fell(bit_clk))
    else $error("frame clock moved off a falling bit edge");
  a_data_edge: assert property ($changed(serial_data_in) |-> $fell(bit_clk))
    else $error("data moved off a falling bit edge");
  a_capture_hold: assert property ($rose(bit_clk) |-> $stable(frame_clk) && $stable(serial_data_in))
    else $error("wires moved at capture edge");
  a_frame_steady: assert property ($changed(frame_clk) |=> $stable(frame_clk) [*8])
    else $error("frame clock toggled too soon");
  a_slot_len: assert property ($changed(frame_clk) && seen_chg |-> half_cnt == 7'h20)
    else $error("slot length not 32 bit clocks");
  a_frame_len: assert property ($rose(frame_clk) && seen_rise |-> frm_cnt == SAR_FRAME_EDGES)
    else $error("frame length not 64 bit clocks");
  c_rise: cover property ($rose(frame_clk) && seen_rise);
  c_fall: cover property ($fell(frame_clk) && seen_chg);
  c_data: cover property ($rose(serial_data_in));
endmodule

// file: tb/stereo_serial_audio_receiver_tb.sv
// Bench for the stereo audio link: source and receiver joined by one link interface.
// Assumes the package, interface, both link ends and sar_sva are compiled first.
`timescale 1ns/10ps
module stereo_serial_audio_receiver_tb;
  import sar_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic nrst_tx = 1'b0;
  sar_fmt_e fmt = SAR_FMT_I2S;
  logic vld = 1'b0;
  logic [23:0] l_in = 24'h0;
  logic [23:0] r_in = 24'h0;
  logic fs;
  logic rx_vld;
  logic resync;
  logic ferr;
  logic [23:0] l_out;
  logic [23:0] r_out;
  logic [23:0] got_l;
  logic [23:0] got_r;
  int got_n = 0;
  int res_n = 0;
  int fe_n = 0;
  int errors = 0;
  int total_checks = 0;
  sar_if link_if ();
  sar_tx sar_tx_i (.clk_in(clk_in), .nrst_in(nrst_tx), .fmt_in(fmt), .sample_valid_in(vld), .left_in(l_in),
    .right_in(r_in), .frame_start_out(fs), .link(link_if.src));
  sar_rx sar_rx_i (.clk_in(clk_in), .nrst_in(nrst_in), .fmt_in(fmt), .left_out(l_out), .right_out(r_out),
    .sample_valid_out(rx_vld), .resync_out(resync), .frame_err_out(ferr), .link(link_if.rcv));
  sar_sva sar_sva_i (.clk_in(clk_in), .nrst_in(nrst_tx), .bit_clk(link_if.bit_clk),
    .frame_clk(link_if.frame_clk), .serial_data_in(link_if.serial_data_in));
  // Master clock, 100 ns period
  always #50 clk_in = ~clk_in;
  // Latch received pairs and count fault pulses
  always @(posedge clk_in) begin
    if (rx_vld === 1'b1) begin
      got_l <= l_out;
      got_r <= r_out;
      got_n <= got_n + 1;
    end
    if (resync === 1'b1) begin
      res_n <= res_n + 1;
    end
    if (ferr === 1'b1) begin
      fe_n <= fe_n + 1;
    end
  end
  // Compare and report
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Print counts and verdict, then stop
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Wait a bounded time for a frame start
  task automatic wait_fs;
    int k;
    k = 0;
    do begin
      @(posedge clk_in);
      #1;
      k++;
    end while (fs !== 1'b1 && k < 800);
    check("frame_start", 64'(fs), 64'h1);
  endtask
  // Send one pair, capture its frame on the wires, judge wires and receiver
  task automatic send_pair(input logic [23:0] l, input logic [23:0] r, input bit judge);
    logic [63:0] dat;
    logic [63:0] frm;
    logic [63:0] exp_d;
    int n;
    l_in = l;
    r_in = r;
    vld = 1'b1;
    @(posedge clk_in);
    #1;
    vld = 1'b0;
    wait_fs();
    n = got_n;
    for (int p = 63; p >= 0; p--) begin
      @(posedge link_if.bit_clk);
      dat[p] = link_if.serial_data_in;
      frm[p] = link_if.frame_clk;
    end
    @(posedge clk_in);
    #1;
    // Unused slot positions must be driven low as well
    exp_d = (fmt == SAR_FMT_I2S) ? {1'b0, l, 8'h00, r, 7'h00} : {l, 8'h00, r, 8'h00};
    if (judge) begin
      check("frame_clk", frm, (fmt == SAR_FMT_I2S) ? {32'h0, 32'hffffffff} : {32'hffffffff, 32'h0});
      check("serial_data", dat, exp_d);
      check("pairs", 64'(got_n - n), 64'h1);
      check("left_out", 64'(got_l), 64'(l));
      check("right_out", 64'(got_r), 64'(r));
    end
  endtask
  // Restart the source in one format, then stream boundary pairs free of faults
  task automatic t_format(input sar_fmt_e f);
    int res0;
    int fe0;
    nrst_tx = 1'b0;
    fmt = f;
    repeat (4) @(posedge clk_in);
    #1;
    nrst_tx = 1'b1;
    repeat (2) send_pair(24'h123456, 24'hfedcba, 1'b0);
    res0 = res_n;
    fe0 = fe_n;
    send_pair(24'h800001, 24'h7ffffe, 1'b1);
    send_pair(24'hffffff, 24'h000000, 1'b1);
    check("resyncs", 64'(res_n - res0), 64'h0);
    check("frame_errs", 64'(fe_n - fe0), 64'h0);
  endtask
  // Cut a frame short mid-stream, expect a flagged fault, then one clean pair
  task automatic t_resync;
    int res0;
    int fe0;
    res0 = res_n;
    fe0 = fe_n;
    repeat (100) @(posedge clk_in);
    #1;
    nrst_tx = 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    nrst_tx = 1'b1;
    repeat (2) send_pair(24'h0f0f0f, 24'hf0f0f0, 1'b0);
    check("resync_seen", 64'(res_n > res0), 64'h1);
    check("frame_err_seen", 64'(fe_n > fe0), 64'h1);
    send_pair(24'h5a5a5a, 24'ha5a5a5, 1'b1);
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_in);
    #1;
    nrst_in = 1'b1;
    t_format(SAR_FMT_I2S);
    t_format(SAR_FMT_LEFT_JUSTIFIED);
    t_resync();
    tally_and_finish();
  end
  // Watchdog
  initial begin
    #3000000;
    errors++;
    tally_and_finish();
  end
endmodule
